//--- dma_pkg.sv
// constants, modes and carriers of the eight-channel peripheral dma engine
// assumes one system clock; peripherals and dma ram answer on the same clock
package dma_pkg;
	localparam int NUM_CHAN = 8;
	localparam int NUM_SRC = 19;
	// dma ram is 2 kbytes, byte addressed
	localparam int RAM_AW = 11;
	localparam int CNT_W = 10;
	localparam logic [6:0] SRC_IRQ [NUM_SRC] = '{7'h00, 7'h01, 7'h02, 7'h05, 7'h06, 7'h07,
		7'h08, 7'h0A, 7'h21, 7'h0B, 7'h0C, 7'h1E, 7'h1F, 7'h0D, 7'h15, 7'h22, 7'h46, 7'h37,
		7'h47};
	// register index inside a channel's group of eight words
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_REQSEL = 3'h1;
	localparam logic [2:0] REG_STA = 3'h2;
	localparam logic [2:0] REG_STB = 3'h3;
	localparam logic [2:0] REG_COUNT = 3'h4;
	localparam logic [2:0] REG_FORCE = 3'h5;
	localparam logic [2:0] REG_STATUS = 3'h6;
	localparam logic [2:0] REG_PTR = 3'h7;
	// field positions
	localparam int CTRL_EN = 0;
	localparam int CTRL_DIR = 1;
	localparam int CTRL_BYTE = 2;
	localparam int CTRL_AM = 3;
	localparam int CTRL_BM = 5;
	localparam int CTRL_HALF = 7;
	localparam int STAT_HALF = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_PP = 2;
	localparam int STAT_PEND = 3;
	localparam int PTR_XFER = 16;
	// addressing and block modes
	localparam logic [1:0] AM_POSTINC = 2'h0;
	localparam logic [1:0] AM_FIXED = 2'h1;
	localparam logic [1:0] AM_PERIND = 2'h2;
	localparam logic [1:0] BM_CONT = 2'h0;
	localparam logic [1:0] BM_ONESHOT = 2'h1;
	localparam logic [1:0] BM_PINGPONG = 2'h2;
	localparam logic [1:0] BUF_DEPTH = 2'h2;
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_READ = 2'b10} fsm_t;
	typedef struct packed {
		logic valid;
		logic at_ram;
		logic [RAM_AW-1:0] addr;
		logic [6:0] sel;
		logic byte_mode;
		logic [15:0] wdata;
	} xfer_req_t;
	typedef struct packed {
		logic en;
		logic dir;
		logic byte_mode;
		logic [1:0] amode;
		logic [1:0] bmode;
		logic half_ie;
		logic [6:0] sel;
		logic [RAM_AW-1:0] sta;
		logic [RAM_AW-1:0] stb;
		logic [RAM_AW-1:0] ptr;
		logic [RAM_AW-1:0] off;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] xfer;
		logic pend;
		logic pp;
		logic half;
		logic done;
	} chan_t;
	typedef struct packed {
		chan_t [NUM_CHAN-1:0] ch;
		fsm_t fsm;
		logic [2:0] act;
		xfer_req_t src;
		xfer_req_t dst;
		xfer_req_t [1:0] buffer;
		logic wp;
		logic rp;
		logic [1:0] fill;
		logic ack;
		logic [31:0] rdata;
		logic [NUM_CHAN-1:0] irq;
	} state_t;
	localparam state_t STATE_RST = '{fsm: ST_IDLE, default: '0};
endpackage

//--- peripheral_dma.sv
// eight-channel dma engine: avalon-mm register slave, source and destination buses
// assumes peripherals and dma ram share i_clock; ready inputs may stall any time
`timescale 1ns/1ps
`default_nettype none
module peripheral_dma (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// avalon-mm register slave
	input wire logic [5:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// peripheral requests, one pulse per element
	input wire logic [dma_pkg::NUM_SRC-1:0] i_periph_req,
	input wire logic [dma_pkg::RAM_AW-1:0] i_per_offset,
	// source read bus
	output dma_pkg::xfer_req_t o_src,
	input wire logic i_src_ready,
	input wire logic [15:0] i_src_rdata,
	// destination write bus
	output dma_pkg::xfer_req_t o_dst,
	input wire logic i_dst_ready,
	// per-channel interrupt requests
	output logic [dma_pkg::NUM_CHAN-1:0] o_chan_irq
);
	import dma_pkg::*;

	state_t s;
	state_t next_s;
	logic [NUM_CHAN-1:0] elig;
	logic [NUM_CHAN-1:0] force_set;
	logic [2:0] grant;
	logic grant_ok;
	logic [2:0] ci;
	logic [RAM_AW-1:0] base;
	logic [RAM_AW-1:0] ram_addr;
	logic [RAM_AW-1:0] inc;
	logic [CNT_W-1:0] nx;
	logic [31:0] mask;
	logic [31:0] merged;
	logic [31:0] wm;
	logic push;
	logic pop;
	logic end_evt;
	logic accept;
	logic [RAM_AW-1:0] act_ptr;
	logic [1:0] act_amode;
	logic act_byte;

	function automatic logic req_hit(input logic [6:0] sel, input logic [NUM_SRC-1:0] req);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < NUM_SRC; k++) begin
			if (req[k] && sel == SRC_IRQ[k]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	function automatic logic [31:0] reg_word(input chan_t c, input logic [2:0] r);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (r)
			REG_CTRL: begin
				w[CTRL_EN] = c.en;
				w[CTRL_DIR] = c.dir;
				w[CTRL_BYTE] = c.byte_mode;
				w[CTRL_AM +: 2] = c.amode;
				w[CTRL_BM +: 2] = c.bmode;
				w[CTRL_HALF] = c.half_ie;
			end
			REG_REQSEL: w[6:0] = c.sel;
			REG_STA: w[RAM_AW-1:0] = c.sta;
			REG_STB: w[RAM_AW-1:0] = c.stb;
			REG_COUNT: w[CNT_W-1:0] = c.cnt;
			REG_STATUS: begin
				w[STAT_HALF] = c.half;
				w[STAT_DONE] = c.done;
				w[STAT_PP] = c.pp;
				w[STAT_PEND] = c.pend;
			end
			REG_PTR: begin
				w[RAM_AW-1:0] = c.ptr;
				w[PTR_XFER +: CNT_W] = c.xfer;
			end
			default: w = 32'h0000_0000;
		endcase
		return w;
	endfunction

	always_comb begin
		next_s = s;
		next_s.irq = '0;
		force_set = '0;
		elig = '0;
		grant = 3'h0;
		grant_ok = 1'b0;
		ci = i_address[5:3];
		base = '0;
		ram_addr = '0;
		inc = '0;
		nx = '0;
		push = 1'b0;
		pop = 1'b0;
		end_evt = 1'b0;
		mask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}}, {8{i_byteenable[1]}},
			{8{i_byteenable[0]}}};
		merged = (reg_word(s.ch[ci], i_address[2:0]) & ~mask) | (i_writedata & mask);
		wm = i_writedata & mask;

		// one wait cycle, then the answer
		next_s.ack = (i_read || i_write) && !s.ack;
		if (i_read && !s.ack) begin
			next_s.rdata = reg_word(s.ch[ci], i_address[2:0]);
		end
		if (s.ack && i_write) begin
			case (i_address[2:0])
				REG_CTRL: begin
					if (merged[CTRL_EN] && !s.ch[ci].en) begin
						next_s.ch[ci].ptr = s.ch[ci].sta;
						next_s.ch[ci].xfer = '0;
						next_s.ch[ci].pp = 1'b0;
					end
					next_s.ch[ci].en = merged[CTRL_EN];
					next_s.ch[ci].dir = merged[CTRL_DIR];
					next_s.ch[ci].byte_mode = merged[CTRL_BYTE];
					next_s.ch[ci].amode = merged[CTRL_AM +: 2];
					next_s.ch[ci].bmode = merged[CTRL_BM +: 2];
					next_s.ch[ci].half_ie = merged[CTRL_HALF];
				end
				REG_REQSEL: next_s.ch[ci].sel = merged[6:0];
				REG_STA: next_s.ch[ci].sta = merged[RAM_AW-1:0];
				REG_STB: next_s.ch[ci].stb = merged[RAM_AW-1:0];
				REG_COUNT: next_s.ch[ci].cnt = merged[CNT_W-1:0];
				REG_FORCE: force_set[ci] = wm[0];
				REG_STATUS: begin
					next_s.ch[ci].half = s.ch[ci].half & ~wm[STAT_HALF];
					next_s.ch[ci].done = s.ch[ci].done & ~wm[STAT_DONE];
				end
				default: ;
			endcase
		end

		for (int c = 0; c < NUM_CHAN; c++) begin
			elig[c] = s.ch[c].en && s.ch[c].pend;
		end
		for (int c = NUM_CHAN - 1; c >= 0; c--) begin
			if (elig[c]) begin
				grant = 3'(c);
				grant_ok = 1'b1;
			end
		end

		case (s.fsm)
			ST_IDLE: begin
				if (grant_ok && s.fill != BUF_DEPTH) begin
					base = s.ch[grant].pp ? s.ch[grant].stb : s.ch[grant].sta;
					if (s.ch[grant].amode == AM_PERIND) begin
						ram_addr = base + s.ch[grant].off;
					end else begin
						ram_addr = s.ch[grant].ptr;
					end
					next_s.act = grant;
					// source read bus: dma ram when dir is set, the selected peripheral otherwise
					next_s.src.valid = 1'b1;
					next_s.src.at_ram = s.ch[grant].dir;
					next_s.src.addr = ram_addr;
					next_s.src.sel = s.ch[grant].sel;
					next_s.src.byte_mode = s.ch[grant].byte_mode;
					next_s.src.wdata = 16'h0000;
					next_s.fsm = ST_READ;
				end
			end
			ST_READ: begin
				if (i_src_ready) begin
					push = 1'b1;
					next_s.buffer[s.wp] = s.src;
					next_s.buffer[s.wp].at_ram = !s.src.at_ram;
					next_s.buffer[s.wp].wdata = s.src.byte_mode ? {8'h00, i_src_rdata[7:0]} :
						i_src_rdata;
					next_s.wp = !s.wp;
					next_s.src.valid = 1'b0;
					next_s.fsm = ST_IDLE;
					next_s.ch[s.act].pend = 1'b0;
					nx = s.ch[s.act].xfer + 10'h001;
					next_s.ch[s.act].xfer = nx;
					inc = s.ch[s.act].byte_mode ? 11'h001 : 11'h002;
					if (s.ch[s.act].amode == AM_POSTINC) begin
						next_s.ch[s.act].ptr = s.ch[s.act].ptr + inc;
					end
					if (nx == {1'b0, s.ch[s.act].cnt[CNT_W-1:1]} && s.ch[s.act].cnt > 10'h001) begin
						next_s.ch[s.act].half = 1'b1;
						next_s.irq[s.act] = s.ch[s.act].half_ie;
					end
					if (nx == s.ch[s.act].cnt) begin
						end_evt = 1'b1;
						next_s.ch[s.act].done = 1'b1;
						next_s.irq[s.act] = !s.ch[s.act].half_ie;
						next_s.ch[s.act].xfer = '0;
						next_s.ch[s.act].ptr = s.ch[s.act].sta;
						case (s.ch[s.act].bmode)
							BM_ONESHOT: next_s.ch[s.act].en = 1'b0;
							BM_PINGPONG: begin
								next_s.ch[s.act].pp = !s.ch[s.act].pp;
								if (!s.ch[s.act].pp) begin
									next_s.ch[s.act].ptr = s.ch[s.act].stb;
								end
							end
							default: next_s.ch[s.act].ptr = s.ch[s.act].sta;
						endcase
					end
				end
			end
			default: next_s.fsm = ST_IDLE;
		endcase

		if (!s.dst.valid || i_dst_ready) begin
			if (s.fill != 2'h0) begin
				pop = 1'b1;
				next_s.dst = s.buffer[s.rp];
				next_s.dst.valid = 1'b1;
				next_s.rp = !s.rp;
			end else begin
				next_s.dst.valid = 1'b0;
			end
		end
		next_s.fill = 2'(s.fill + {1'b0, push} - {1'b0, pop});

		// peripheral or software start, set wins
		for (int c = 0; c < NUM_CHAN; c++) begin
			if (req_hit(s.ch[c].sel, i_periph_req)) begin
				next_s.ch[c].pend = 1'b1;
				next_s.ch[c].off = i_per_offset;
			end
			if (force_set[c]) begin
				next_s.ch[c].pend = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s <= STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	assign o_readdata = s.rdata;
	assign o_waitrequest = (i_read || i_write) && !s.ack;
	assign o_src = s.src;
	assign o_dst = s.dst;
	assign o_chan_irq = s.irq;

	// helpers for the checks
	assign accept = (s.fsm == ST_READ) && i_src_ready;
	assign act_ptr = s.ch[s.act].ptr;
	assign act_amode = s.ch[s.act].amode;
	assign act_byte = s.ch[s.act].byte_mode;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_b);

	bus_wait_once_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
		else $error("waitrequest held longer than one cycle");
	src_hold_a: assert property (o_src.valid && !i_src_ready |=> o_src.valid && $stable(o_src))
		else $error("source request changed before ready");
	dst_hold_a: assert property (o_dst.valid && !i_dst_ready |=> o_dst.valid && $stable(o_dst))
		else $error("destination request changed before ready");
	buf_bound_a: assert property (s.fill <= BUF_DEPTH)
		else $error("buffer overfilled");
	src_dir_a: assert property (o_src.valid |-> o_src.at_ram == s.ch[s.act].dir)
		else $error("source side does not follow channel direction");
	prio_fixed_a: assert property (s.fsm == ST_IDLE && grant_ok |-> (elig & ((8'h01 << grant) - 8'h01)) == 8'h00)
		else $error("higher priority channel skipped");
	ptr_step_a: assert property (accept && act_amode == AM_POSTINC && !end_evt |=> act_ptr == $past(act_ptr) + ($past(act_byte) ? 11'h001 : 11'h002))
		else $error("pointer step wrong for element size");
	ptr_fixed_a: assert property (accept && act_amode == AM_FIXED && !end_evt |=> $stable(act_ptr))
		else $error("fixed pointer moved");
	oneshot_stop_a: assert property (end_evt && s.ch[s.act].bmode == BM_ONESHOT |=> !s.ch[$past(s.act)].en)
		else $error("one-shot channel still enabled after block");
	irq_single_a: assert property (o_chan_irq != 8'h00 |-> $onehot(o_chan_irq) && $past(accept))
		else $error("interrupt without a completed element");
	byte_zero_a: assert property (o_dst.valid && o_dst.byte_mode |-> o_dst.wdata[15:8] == 8'h00)
		else $error("byte element carries upper data");
endmodule
`default_nettype wire

//--- periph_ram_model.sv
// behavioural peripherals and dma ram facing the engine's source and destination buses
// assumes the engine's clock; i_slow makes both buses stall at random cycles
`timescale 1ns/1ps
`default_nettype none
module periph_ram_model (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// engine buses
	input wire dma_pkg::xfer_req_t i_src,
	input wire dma_pkg::xfer_req_t i_dst,
	input wire logic i_slow,
	output logic o_src_ready,
	output logic [15:0] o_src_rdata,
	output logic o_dst_ready
);
	import dma_pkg::*;
	logic go_s;
	logic go_d;
	logic [15:0] noise = 16'h1234;
	always @(posedge i_clock) begin
		go_s <= !i_slow || ($urandom_range(2) == 0);
		go_d <= !i_slow || ($urandom_range(2) == 0);
		noise <= noise + 16'h9E37;
	end
	assign o_src_ready = i_src.valid & go_s;
	assign o_dst_ready = i_dst.valid & go_d;
	// data only valid with ready, a moving pattern otherwise
	assign o_src_rdata = o_src_ready ? (i_src.at_ram ? {5'h1A, i_src.addr} : {i_src.sel, 9'h0B5})
		: noise;
endmodule
`default_nettype wire

//--- multichannel_peripheral_dma_test.sv
// self-checking bench of the peripheral dma engine with a stalling far-side model
// assumes one 250 MHz clock; every register access goes over the avalon-mm port
`timescale 1ns/1ps
`default_nettype none
module multichannel_peripheral_dma_test;
	import dma_pkg::*;
	logic i_clock = 1'b0;
	logic i_rst_b = 1'b0;
	logic [5:0] i_address = '0;
	logic i_read = 1'b0;
	logic i_write = 1'b0;
	logic [31:0] i_writedata = '0;
	logic [NUM_SRC-1:0] i_periph_req = '0;
	logic [RAM_AW-1:0] i_per_offset = '0;
	logic slow = 1'b0;
	logic src_ready;
	logic dst_ready;
	logic [15:0] src_rdata;
	logic [31:0] o_readdata;
	logic o_waitrequest;
	xfer_req_t o_src;
	xfer_req_t o_dst;
	logic [NUM_CHAN-1:0] o_chan_irq;
	xfer_req_t wq[$];
	int irq_n[NUM_CHAN];
	int fail_count = 0;
	int tests_run = 0;
	peripheral_dma dut_u (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_address(i_address),
		.i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hF),
		.o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_periph_req(i_periph_req),
		.i_per_offset(i_per_offset), .o_src(o_src), .i_src_ready(src_ready),
		.i_src_rdata(src_rdata), .o_dst(o_dst), .i_dst_ready(dst_ready), .o_chan_irq(o_chan_irq));
	periph_ram_model far_u (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_src(o_src), .i_dst(o_dst),
		.i_slow(slow), .o_src_ready(src_ready), .o_src_rdata(src_rdata), .o_dst_ready(dst_ready));
	initial forever #2 i_clock = ~i_clock;
	// collect accepted writes and irq pulses mid-cycle
	always @(negedge i_clock) begin
		if (o_dst.valid === 1'b1 && dst_ready === 1'b1)
			wq.push_back(o_dst);
		for (int c = 0; c < NUM_CHAN; c++)
			if (o_chan_irq[c] === 1'b1)
				irq_n[c]++;
	end
	task automatic test_done();
		if (fail_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#300000;
		fail_count++;
		test_done();
	end
	task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		i_address <= a;
		i_writedata <= d;
		i_write <= w;
		i_read <= !w;
		do begin
			@(posedge i_clock);
			n++;
		end while (o_waitrequest !== 1'b0 && n < 40);
		q = o_readdata;
		if (n >= 40) begin
			fail_count++;
			test_done();
		end
		i_write <= 1'b0;
		i_read <= 1'b0;
		@(posedge i_clock);
	endtask
	task automatic wr(input int ch, input logic [2:0] r, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, {ch[2:0], r}, d, q);
	endtask
	task automatic rd_chk(input string what, input int ch, input logic [2:0] r,
		input logic [31:0] e, input logic [31:0] m);
		logic [31:0] q;
		bus(1'b0, {ch[2:0], r}, '0, q);
		compare(what, e, q & m);
	endtask
	task automatic do_reset(input int n);
		i_rst_b <= 1'b0;
		repeat (n) @(posedge i_clock);
		i_rst_b <= 1'b1;
		@(posedge i_clock);
		wq.delete();
		foreach (irq_n[c])
			irq_n[c] = 0;
	endtask
	task automatic pulse(input int k, input logic [10:0] off);
		i_periph_req <= NUM_SRC'(1) << k;
		i_per_offset <= off;
		@(posedge i_clock);
		i_periph_req <= '0;
		@(posedge i_clock);
	endtask
	function automatic logic [10:0] exp_addr(input logic [1:0] am, input logic [10:0] base,
		input int i, input logic b, input logic [10:0] off);
		case (am)
			AM_POSTINC: return base + 11'(b ? i : 2 * i);
			AM_FIXED: return base;
			default: return base + off;
		endcase
	endfunction
	task automatic expect_wr(input logic dir, input logic [10:0] a, input logic [6:0] s,
		input logic b);
		int n;
		logic [15:0] raw;
		xfer_req_t w;
		n = 0;
		raw = dir ? {5'h1A, a} : {s, 9'h0B5};
		while (wq.size() == 0 && n < 200) begin
			@(posedge i_clock);
			n++;
		end
		w = (wq.size() > 0) ? wq.pop_front() : '0;
		compare("dst write", {4'h0, !dir, dir ? {4'h0, s} : a, b ? {8'h00, raw[7:0]} : raw},
			{4'h0, w.valid & w.at_ram, w.at_ram ? w.addr : {4'h0, w.sel}, w.wdata});
	endtask
	initial begin
		logic [1:0] am;
		logic [1:0] bm;
		logic [10:0] sta;
		logic [10:0] stb;
		logic [10:0] base;
		logic [10:0] off;
		logic dir;
		logic b;
		logic hf;
		logic pp;
		logic frc;
		int ch;
		int k;
		int cnt;
		int irqs;
		repeat (6) @(posedge i_clock);
		i_rst_b <= 1'b1;
		@(posedge i_clock);
		void'($urandom(37));
		rd_chk("ctrl after reset", 7, REG_CTRL, 32'h0, 32'hFFFFFFFF);
		for (int t = 0; t < 36; t++) begin
			do_reset(2);
			ch = $urandom_range(7);
			k = $urandom_range(NUM_SRC - 1);
			dir = $urandom_range(1);
			b = $urandom_range(1);
			hf = $urandom_range(1);
			am = 2'(t % 3);
			bm = 2'((t / 3) % 3);
			cnt = $urandom_range(5, 2);
			sta = 11'($urandom) & 11'h3F0;
			stb = sta | 11'h400;
			slow <= t[0];
			wr(ch, REG_REQSEL, {25'h0, SRC_IRQ[k]});
			wr(ch, REG_STA, {21'h0, sta});
			wr(ch, REG_STB, {21'h0, stb});
			wr(ch, REG_COUNT, 32'(cnt));
			wr(ch, REG_CTRL, {24'h0, hf, bm, am, b, dir, 1'b1});
			rd_chk("pointer loaded", ch, REG_PTR, {21'h0, sta}, 32'hFFFFFFFF);
			wr(ch, REG_PTR, 32'h7FF);
			rd_chk("pointer kept", ch, REG_PTR, {21'h0, sta}, 32'hFFFFFFFF);
			pp = 1'b0;
			irqs = 0;
			for (int blk = 0; blk < 2; blk++) begin
				base = pp ? stb : sta;
				for (int i = 0; i < cnt; i++) begin
					off = 11'($urandom) & 11'h0FE;
					frc = (am != AM_PERIND) && $urandom_range(1);
					if (frc)
						wr(ch, REG_FORCE, 32'h1);
					else
						pulse(k, off);
					if (bm == BM_ONESHOT && blk == 1) begin
						repeat (30) @(posedge i_clock);
						compare("one-shot stopped", 32'h0, wq.size());
						break;
					end
					expect_wr(dir, exp_addr(am, base, i, b, off), SRC_IRQ[k], b);
					repeat (3) @(posedge i_clock);
					if (i + 1 == (hf ? cnt / 2 : cnt))
						irqs++;
					compare("irq count", irqs, irq_n[ch]);
				end
				if (bm == BM_ONESHOT && blk == 1)
					break;
				rd_chk("block status", ch, REG_STATUS,
					{29'h0, bm == BM_PINGPONG && !pp, 2'b10}, 32'h6);
				wr(ch, REG_STATUS, 32'h3);
				rd_chk("enable kept", ch, REG_CTRL, {31'h0, bm != BM_ONESHOT}, 32'h1);
				if (bm == BM_PINGPONG)
					pp = !pp;
			end
		end
		do_reset(3);
		slow <= 1'b1;
		for (int c = 0; c < 2; c++) begin
			wr(c ? 1 : 6, REG_REQSEL, {25'h0, SRC_IRQ[3]});
			wr(c ? 1 : 6, REG_STA, c ? 32'h100 : 32'h500);
			wr(c ? 1 : 6, REG_CTRL, 32'h1);
		end
		pulse(3, 11'h0);
		expect_wr(1'b0, 11'h100, SRC_IRQ[3], 1'b0);
		expect_wr(1'b0, 11'h500, SRC_IRQ[3], 1'b0);
		test_done();
	end
endmodule
`default_nettype wire
